// [src/memory_coherency_policy.sv]
// load/store attribute policy, small primary tag array and gather buffer
`timescale 1ns/1ps
`include "coherency_regs.svh"
module memory_coherency_policy
    import coherency_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // pipeline request
    input wire logic REQ_VALID_I,
    input wire logic REQ_WRITE_I,
    input wire logic REQ_SYNC_I,
    input wire logic REQ_HIT_INVAL_I,
    input wire logic REQ_HIT_WB_INVAL_I,
    input wire logic [63:0] REQ_VADDR_I,
    input wire logic [`ADDR_W-1:0] REQ_PADDR_I,
    input wire logic [`ATTR_W-1:0] REQ_ATTR_I,
    input wire logic [31:0] REQ_WDATA_I,
    input wire logic LOADS_PENDING_I,
    // pipeline answer
    output logic STALL_O,
    output logic DONE_O,
    output logic [31:0] RDATA_O,
    // secondary cache
    output logic L2_LOOK_O,
    output logic L2_WRITE_O,
    output logic [`ADDR_W-1:0] L2_ADDR_O,
    input wire logic L2_DONE_I,
    input wire logic L2_HIT_I,
    // external bus
    output logic BUS_REQ_O,
    output logic BUS_PRIORITY_O,
    output bus_kind_type BUS_KIND_O,
    output logic BUS_WRITE_O,
    output logic [`ADDR_W-1:0] BUS_ADDR_O,
    output logic [31:0] BUS_WDATA_O,
    input wire logic BUS_DONE_I,
    input wire logic [31:0] BUS_RDATA_I
);
    // no snoop port exists; coherency is left to software
    // attribute arrives per access from the translation entry
    state_type state_reg;
    policy_type policy;
    logic [`TAG_W-1:0] look_tag;
    logic [`SET_W-1:0] set_idx;
    logic [(1<<`SET_W)-1:0] hit_vec, dirty_vec, fill_vec, inval_vec;
    logic [(1<<`SET_W)-1:0] dset_vec;
    logic [`TAG_W-1:0] tag_arr [(1<<`SET_W)];
    logic hit, dirty_hit;
    logic [31:0] gather_reg [`LINE_WORDS];
    logic [`LINE_WORDS-1:0] gvalid_reg;
    logic [`ADDR_W-1:0] gbase_reg;
    logic [`WORD_IDX_W-1:0] gnext_reg, drain_idx_reg;
    logic [`ADDR_W-1:0] pend_addr_reg;
    logic pend_write_reg, pend_mem_reg, pend_fill_reg;
    logic gather_active;
    logic seq_store;
    logic accept;

    attr_decode u_decode (
        .vaddr_i(REQ_VADDR_I),
        .page_attr_i(REQ_ATTR_I),
        .policy_o(policy)
    );

    assign look_tag = REQ_PADDR_I[`TAG_MSB:`TAG_LSB];
    assign set_idx = REQ_PADDR_I[`SET_MSB:`SET_LSB];

    genvar g;
    generate
        for (g = 0; g < (1<<`SET_W); g++) begin : g_set
            primary_tag_set u_set (
                .clk_i(CORE_CLK_I),
                .arst_n_i(ARST_N_I),
                .fill_i(fill_vec[g]),
                .dirty_set_i(dset_vec[g]),
                .inval_i(inval_vec[g]),
                .fill_tag_i(pend_addr_reg[`TAG_MSB:`TAG_LSB]),
                .look_tag_i(look_tag),
                .hit_o(hit_vec[g]),
                .dirty_o(dirty_vec[g]),
                .tag_o(tag_arr[g])
            );
        end
    endgenerate

    assign hit = hit_vec[set_idx];
    assign dirty_hit = dirty_vec[set_idx];
    assign gather_active = |gvalid_reg;
    assign accept = REQ_VALID_I && state_reg == ST_IDLE && !STALL_O;
    assign seq_store = REQ_WRITE_I && policy == POL_ACCEL &&
        (!gather_active ||
         (REQ_PADDR_I[`LINE_ADDR_MSB:`LINE_ADDR_LSB] ==
          gbase_reg[`LINE_ADDR_MSB:`LINE_ADDR_LSB] &&
          REQ_PADDR_I[`WORD_IDX_MSB:`WORD_IDX_LSB] == gnext_reg));

    // tag array updates
    always_comb begin
        fill_vec = '0;
        inval_vec = '0;
        dset_vec = '0;
        if (pend_fill_reg && ((state_reg == ST_L2_LOOK && L2_DONE_I &&
            L2_HIT_I) || (state_reg == ST_MEM_READ && BUS_DONE_I))) begin
            fill_vec[pend_addr_reg[`SET_MSB:`SET_LSB]] = 1'b1;
            dset_vec[pend_addr_reg[`SET_MSB:`SET_LSB]] = pend_write_reg;
        end
        if (accept && policy == POL_WRITEBACK && hit && REQ_WRITE_I &&
            !REQ_HIT_INVAL_I && !REQ_HIT_WB_INVAL_I) begin
            dset_vec[set_idx] = 1'b1;
        end
        if (state_reg == ST_INVAL) begin
            inval_vec[pend_addr_reg[`SET_MSB:`SET_LSB]] = 1'b1;
        end
    end

    // main sequencer
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_reg <= ST_IDLE;
            pend_addr_reg <= `ZERO_ADDR;
            pend_write_reg <= 1'b0;
            pend_mem_reg <= 1'b0;
            pend_fill_reg <= 1'b0;
            drain_idx_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        pend_addr_reg <= REQ_PADDR_I;
                        pend_write_reg <= REQ_WRITE_I;
                        pend_fill_reg <= 1'b0;
                        if (REQ_HIT_INVAL_I || REQ_HIT_WB_INVAL_I) begin
                            if (hit && dirty_hit && REQ_HIT_WB_INVAL_I) begin
                                state_reg <= ST_WB;
                                pend_addr_reg <= {tag_arr[set_idx],
                                    set_idx, 5'h00};
                            end else if (hit) begin
                                state_reg <= ST_INVAL;
                            end
                            // miss retires at once
                        end else if (gather_active && !seq_store &&
                            policy != POL_WRITEBACK && REQ_WRITE_I) begin
                            state_reg <= ST_DRAIN;
                            drain_idx_reg <= '0;
                        end else if (policy == POL_UNCACHED) begin
                            state_reg <= ST_UC_WAIT;
                        end else if (policy == POL_WRITEBACK && !hit) begin
                            pend_fill_reg <= 1'b1;
                            if (dirty_hit) begin
                                pend_addr_reg <= REQ_PADDR_I;
                            end
                            state_reg <= ST_L2_LOOK;
                        end
                    end
                end
                ST_UC_WAIT: begin
                    if (BUS_DONE_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_L2_LOOK: begin
                    if (L2_DONE_I) begin
                        state_reg <= L2_HIT_I ? ST_IDLE : ST_MEM_READ;
                    end
                end
                ST_MEM_READ: begin
                    if (BUS_DONE_I) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WB: begin
                    if (BUS_DONE_I) begin
                        state_reg <= ST_INVAL;
                    end
                end
                ST_DRAIN: begin
                    if (BUS_DONE_I || !gvalid_reg[drain_idx_reg]) begin
                        drain_idx_reg <= drain_idx_reg + 3'h1;
                        if (drain_idx_reg == `LAST_WORD) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_INVAL: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // gather buffer for accelerated stores
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            gvalid_reg <= '0;
            gbase_reg <= `ZERO_ADDR;
            gnext_reg <= '0;
            for (int i = 0; i < `LINE_WORDS; i++) begin
                gather_reg[i] <= `ZERO_WORD;
            end
        end else if (state_reg == ST_DRAIN && drain_idx_reg == `LAST_WORD &&
            (BUS_DONE_I || !gvalid_reg[drain_idx_reg])) begin
            gvalid_reg <= '0;
        end else if (state_reg == ST_IDLE && BUS_DONE_I &&
            BUS_KIND_O == BUS_BLOCK_WRITE) begin
            gvalid_reg <= '0;
        end else if (accept && seq_store && !REQ_HIT_INVAL_I &&
            !REQ_HIT_WB_INVAL_I) begin
            gather_reg[REQ_PADDR_I[`WORD_IDX_MSB:`WORD_IDX_LSB]] <=
                REQ_WDATA_I;
            gvalid_reg[REQ_PADDR_I[`WORD_IDX_MSB:`WORD_IDX_LSB]] <= 1'b1;
            gnext_reg <= REQ_PADDR_I[`WORD_IDX_MSB:`WORD_IDX_LSB] + 3'h1;
            if (!gather_active) begin
                gbase_reg <= REQ_PADDR_I;
            end
        end
    end

    // external bus request
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            BUS_REQ_O <= 1'b0;
            BUS_PRIORITY_O <= 1'b0;
            BUS_KIND_O <= BUS_NONE;
            BUS_WRITE_O <= 1'b0;
            BUS_ADDR_O <= `ZERO_ADDR;
            BUS_WDATA_O <= `ZERO_WORD;
        end else if (BUS_DONE_I) begin
            BUS_REQ_O <= 1'b0;
            BUS_PRIORITY_O <= 1'b0;
            BUS_KIND_O <= BUS_NONE;
        end else if (accept && policy == POL_UNCACHED && !REQ_HIT_INVAL_I &&
            !REQ_HIT_WB_INVAL_I && !(gather_active && REQ_WRITE_I)) begin
            BUS_REQ_O <= 1'b1;
            BUS_PRIORITY_O <= REQ_WRITE_I;
            BUS_KIND_O <= BUS_SINGLE;
            BUS_WRITE_O <= REQ_WRITE_I;
            BUS_ADDR_O <= REQ_PADDR_I;
            BUS_WDATA_O <= REQ_WDATA_I;
        end else if (state_reg == ST_L2_LOOK && L2_DONE_I && !L2_HIT_I) begin
            BUS_REQ_O <= 1'b1;
            BUS_KIND_O <= BUS_BLOCK_READ;
            BUS_WRITE_O <= 1'b0;
            BUS_ADDR_O <= pend_addr_reg;
        end else if (accept && REQ_HIT_WB_INVAL_I && hit && dirty_hit) begin
            BUS_REQ_O <= 1'b1;
            BUS_KIND_O <= BUS_BLOCK_WRITE;
            BUS_WRITE_O <= 1'b1;
            BUS_ADDR_O <= {tag_arr[set_idx], set_idx, 5'h00};
        end else if (state_reg == ST_DRAIN && !BUS_REQ_O &&
            gvalid_reg[drain_idx_reg]) begin
            BUS_REQ_O <= 1'b1;
            BUS_KIND_O <= BUS_SINGLE;
            BUS_WRITE_O <= 1'b1;
            BUS_ADDR_O <= {gbase_reg[`LINE_ADDR_MSB:`LINE_ADDR_LSB],
                drain_idx_reg, 2'h0};
            BUS_WDATA_O <= gather_reg[drain_idx_reg];
        end else if (state_reg == ST_IDLE && &gvalid_reg && !BUS_REQ_O) begin
            BUS_REQ_O <= 1'b1;
            BUS_KIND_O <= BUS_BLOCK_WRITE;
            BUS_WRITE_O <= 1'b1;
            BUS_ADDR_O <= {gbase_reg[`LINE_ADDR_MSB:`LINE_ADDR_LSB], 5'h00};
        end
    end

    // secondary cache: lookup on primary miss, written by fills only
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            L2_LOOK_O <= 1'b0;
            L2_WRITE_O <= 1'b0;
            L2_ADDR_O <= `ZERO_ADDR;
        end else begin
            L2_LOOK_O <= accept && policy == POL_WRITEBACK && !hit &&
                !REQ_HIT_INVAL_I && !REQ_HIT_WB_INVAL_I;
            L2_WRITE_O <= state_reg == ST_MEM_READ && BUS_DONE_I;
            if (accept) begin
                L2_ADDR_O <= REQ_PADDR_I;
            end
        end
    end

    // pipeline answer; write-back misses retire without stall
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            STALL_O <= 1'b0;
            DONE_O <= 1'b0;
            RDATA_O <= `ZERO_WORD;
        end else begin
            STALL_O <= (state_reg != ST_IDLE && !(state_reg == ST_L2_LOOK ||
                state_reg == ST_MEM_READ)) ||
                (REQ_SYNC_I && (BUS_REQ_O || LOADS_PENDING_I ||
                gather_active)) || (&gvalid_reg) ||
                (accept && policy == POL_UNCACHED && !REQ_HIT_INVAL_I &&
                !REQ_HIT_WB_INVAL_I);
            DONE_O <= (state_reg == ST_UC_WAIT && BUS_DONE_I) ||
                (accept && !REQ_SYNC_I && policy != POL_UNCACHED);
            if (state_reg == ST_UC_WAIT && BUS_DONE_I) begin
                RDATA_O <= BUS_RDATA_I;
            end
        end
    end
endmodule

// [src/coherency_regs.svh]
// constants for the memory attribute policy block
`ifndef COHERENCY_REGS_SVH
`define COHERENCY_REGS_SVH
`define ATTR_W 3
`define ATTR_UNCACHED 3'h2
`define ATTR_WRITEBACK 3'h3
`define ATTR_ACCEL 3'h7
`define LINE_WORDS 8
`define WORD_IDX_W 3
`define WORD_IDX_MSB 4
`define WORD_IDX_LSB 2
`define LAST_WORD 3'h7
`define LINE_ADDR_MSB 39
`define LINE_ADDR_LSB 5
`define SET_W 4
`define SET_MSB 8
`define SET_LSB 5
`define TAG_MSB 39
`define TAG_LSB 9
`define TAG_W 31
`define KSEG_SELECT 3'h5
`define KSEG_MSB 31
`define KSEG_LSB 29
`define XKPHYS_TOP 2'h2
`define XKPHYS_CA_MSB 61
`define XKPHYS_CA_LSB 59
`define ZERO_WORD 32'h0000_0000
`define ZERO_ADDR 40'h00_0000_0000
`define ADDR_W 40
`endif

// [src/coherency_pkg.sv]
// types for the memory attribute policy block
package coherency_pkg;
    typedef enum logic [1:0] {
        POL_UNCACHED = 2'h0,
        POL_WRITEBACK = 2'h1,
        POL_ACCEL = 2'h2
    } policy_type;
    typedef enum logic [1:0] {
        BUS_NONE = 2'h0,
        BUS_SINGLE = 2'h1,
        BUS_BLOCK_READ = 2'h2,
        BUS_BLOCK_WRITE = 2'h3
    } bus_kind_type;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_UC_WAIT = 7'h02,
        ST_L2_LOOK = 7'h04,
        ST_MEM_READ = 7'h08,
        ST_WB = 7'h10,
        ST_DRAIN = 7'h20,
        ST_INVAL = 7'h40
    } state_type;
endpackage

// [src/attr_decode.sv]
// maps a virtual segment and page attribute to a policy
`timescale 1ns/1ps
`include "coherency_regs.svh"
module attr_decode
    import coherency_pkg::*;
(
    input wire logic [63:0] vaddr_i,
    input wire logic [`ATTR_W-1:0] page_attr_i,
    output policy_type policy_o
);
    logic [`ATTR_W-1:0] eff_attr;
    always_comb begin
        eff_attr = page_attr_i;
        if (vaddr_i[`KSEG_MSB:`KSEG_LSB] == `KSEG_SELECT) begin
            eff_attr = `ATTR_UNCACHED;
        end
        if (vaddr_i[63:62] == `XKPHYS_TOP &&
            vaddr_i[`XKPHYS_CA_MSB:`XKPHYS_CA_LSB] == `ATTR_UNCACHED) begin
            eff_attr = `ATTR_UNCACHED;
        end
        unique case (eff_attr)
            `ATTR_WRITEBACK: policy_o = POL_WRITEBACK;
            `ATTR_ACCEL: policy_o = POL_ACCEL;
            default: policy_o = POL_UNCACHED;
        endcase
    end
endmodule

// [src/primary_tag_set.sv]
// one primary data cache set: tag, valid and dirty
`timescale 1ns/1ps
`include "coherency_regs.svh"
module primary_tag_set (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic fill_i,
    input wire logic dirty_set_i,
    input wire logic inval_i,
    input wire logic [`TAG_W-1:0] fill_tag_i,
    input wire logic [`TAG_W-1:0] look_tag_i,
    output logic hit_o,
    output logic dirty_o,
    output logic [`TAG_W-1:0] tag_o
);
    logic valid_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_reg <= 1'b0;
            dirty_o <= 1'b0;
            tag_o <= '0;
        end else if (fill_i) begin
            valid_reg <= 1'b1;
            dirty_o <= dirty_set_i;
            tag_o <= fill_tag_i;
        end else if (inval_i) begin
            valid_reg <= 1'b0;
            dirty_o <= 1'b0;
        end else if (dirty_set_i) begin
            dirty_o <= 1'b1;
        end
    end
    assign hit_o = valid_reg && (tag_o == look_tag_i);
endmodule

// [testbench/coherency_policy_sva.sv]
// port checker for the memory attribute policy block
`timescale 1ns/1ps
`include "coherency_regs.svh"
module coherency_policy_sva
    import coherency_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // pipeline side
    input wire logic REQ_SYNC_I,
    input wire logic LOADS_PENDING_I,
    input wire logic STALL_O,
    input wire logic DONE_O,
    input wire logic [31:0] RDATA_O,
    // secondary cache and bus
    input wire logic L2_DONE_I,
    input wire logic L2_HIT_I,
    input wire logic BUS_REQ_O,
    input wire logic BUS_PRIORITY_O,
    input wire bus_kind_type BUS_KIND_O,
    input wire logic BUS_WRITE_O,
    input wire logic BUS_DONE_I,
    input wire logic [31:0] BUS_RDATA_I
);
    default clocking dc @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    bus_hold_a: assert property (BUS_REQ_O && !BUS_DONE_I |=> BUS_REQ_O
        && $stable(BUS_KIND_O) && $stable(BUS_WRITE_O))
        else $error("bus request dropped or changed early");
    prio_write_a: assert property (BUS_REQ_O && BUS_PRIORITY_O |->
        BUS_WRITE_O && BUS_KIND_O == BUS_SINGLE)
        else $error("priority on a non uncached write");
    uc_read_done_a: assert property (BUS_REQ_O && BUS_DONE_I
        && !BUS_WRITE_O && BUS_KIND_O == BUS_SINGLE
        |=> DONE_O && RDATA_O == $past(BUS_RDATA_I))
        else $error("uncached load answer wrong");
    uc_read_stall_a: assert property (BUS_REQ_O && !BUS_WRITE_O
        && BUS_KIND_O == BUS_SINGLE |-> STALL_O)
        else $error("no stall during uncached load");
    block_dir_a: assert property (BUS_REQ_O && BUS_KIND_O[1] |->
        BUS_WRITE_O == (BUS_KIND_O == BUS_BLOCK_WRITE))
        else $error("block direction wrong");
    sync_stall_a: assert property ((REQ_SYNC_I && LOADS_PENDING_I)[*2]
        |-> STALL_O)
        else $error("barrier did not stall");
    l2_miss_bus_a: assert property (L2_DONE_I && !L2_HIT_I |->
        ##[1:8] (BUS_REQ_O && BUS_KIND_O == BUS_BLOCK_READ))
        else $error("no block read after secondary miss");
    l2_hit_quiet_a: assert property (L2_DONE_I && L2_HIT_I |=>
        !(BUS_REQ_O && BUS_KIND_O == BUS_BLOCK_READ)[*4])
        else $error("block read after secondary hit");
endmodule

// [testbench/bus_memory_model.sv]
// external bus, main memory and secondary cache model
`timescale 1ns/1ps
`include "coherency_regs.svh"
module bus_memory_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // behaviour control
    input wire logic [3:0] lat_i,
    input wire logic l2_mode_i,
    // from the block
    input wire logic bus_req_i,
    input wire logic [`ADDR_W-1:0] bus_addr_i,
    input wire logic l2_look_i,
    // answers
    output logic bus_done_o,
    output logic [31:0] bus_rdata_o,
    output logic l2_done_o,
    output logic l2_hit_o
);
    logic [3:0] wait_reg;
    logic [1:0] l2_wait_reg;
    // bus answers after lat_i cycles; data is only valid with done
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_reg <= 4'h0;
            bus_done_o <= 1'b0;
            bus_rdata_o <= 32'h0;
        end else if (bus_req_i && !bus_done_o && wait_reg == lat_i) begin
            wait_reg <= 4'h0;
            bus_done_o <= 1'b1;
            bus_rdata_o <= bus_addr_i[31:0] ^ 32'h5a5a_0000;
        end else begin
            wait_reg <= (bus_req_i && !bus_done_o) ? wait_reg + 4'h1 : 4'h0;
            bus_done_o <= 1'b0;
            bus_rdata_o <= ~bus_rdata_o;
        end
    end
    // secondary lookup answers three cycles after the request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            l2_wait_reg <= 2'h0;
            l2_done_o <= 1'b0;
            l2_hit_o <= 1'b0;
        end else begin
            l2_wait_reg <= l2_look_i ? 2'h2 : l2_wait_reg - {1'b0, |l2_wait_reg};
            l2_done_o <= l2_wait_reg == 2'h1;
            l2_hit_o <= (l2_wait_reg == 2'h1) ? l2_mode_i : ~l2_hit_o;
        end
    end
endmodule

// [testbench/memory_coherency_policy_bench.sv]
// self-checking bench for the memory attribute policy block
`timescale 1ns/1ps
`include "coherency_regs.svh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    err_total++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module memory_coherency_policy_bench;
    import coherency_pkg::*;
    logic clk, rst_n, valid, wr, sync, hinv, hwb, pend, l2_mode;
    logic stall, done, l2_look, l2_wr, l2_done, l2_hit;
    logic bus_req, bus_prio, bus_wr, bus_done;
    logic [63:0] vaddr;
    logic [`ADDR_W-1:0] paddr, l2_addr, bus_addr;
    logic [2:0] attr;
    logic [3:0] lat;
    logic [31:0] wdata, rdata, bus_wd, bus_rd, last_wd, got;
    bus_kind_type kind;
    int err_total = 0;
    int cmp_count = 0;
    int n_rd, n_wr, n_brd, n_bwr, n_look, n_l2w, n_prio, n_stall;
    memory_coherency_policy DUT (.CORE_CLK_I(clk), .ARST_N_I(rst_n),
        .REQ_VALID_I(valid), .REQ_WRITE_I(wr), .REQ_SYNC_I(sync),
        .REQ_HIT_INVAL_I(hinv), .REQ_HIT_WB_INVAL_I(hwb),
        .REQ_VADDR_I(vaddr), .REQ_PADDR_I(paddr), .REQ_ATTR_I(attr),
        .REQ_WDATA_I(wdata), .LOADS_PENDING_I(pend), .STALL_O(stall),
        .DONE_O(done), .RDATA_O(rdata), .L2_LOOK_O(l2_look),
        .L2_WRITE_O(l2_wr), .L2_ADDR_O(l2_addr), .L2_DONE_I(l2_done),
        .L2_HIT_I(l2_hit), .BUS_REQ_O(bus_req), .BUS_PRIORITY_O(bus_prio),
        .BUS_KIND_O(kind), .BUS_WRITE_O(bus_wr), .BUS_ADDR_O(bus_addr),
        .BUS_WDATA_O(bus_wd), .BUS_DONE_I(bus_done), .BUS_RDATA_I(bus_rd));
    bus_memory_model far (.clk_i(clk), .arst_n_i(rst_n), .lat_i(lat),
        .l2_mode_i(l2_mode), .bus_req_i(bus_req), .bus_addr_i(bus_addr),
        .l2_look_i(l2_look), .bus_done_o(bus_done), .bus_rdata_o(bus_rd),
        .l2_done_o(l2_done), .l2_hit_o(l2_hit));
    always #12.5 clk = ~clk;
    // traffic counters seen at the far side
    always @(posedge clk) begin
        if (bus_req && bus_done) begin
            last_wd = bus_wd;
            n_rd += (kind == BUS_SINGLE && !bus_wr);
            n_wr += (kind == BUS_SINGLE && bus_wr);
            n_brd += (kind == BUS_BLOCK_READ);
            n_bwr += (kind == BUS_BLOCK_WRITE);
        end
        n_look += l2_look;
        n_l2w += l2_wr;
        n_prio += (bus_req && bus_prio);
        n_stall += stall;
    end
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // wait for 8 idle cycles, then check that the block settled
    task automatic quiet();
        int q;
        q = 0;
        for (int k = 0; k < 600 && q < 8; k++) begin
            @(posedge clk);
            #2;
            q = (!bus_req && !stall && !l2_look) ? q + 1 : 0;
        end
        `CHK("settle", 1'b1, q >= 8)
    endtask
    // clear the traffic counters before a scenario step
    task automatic clr();
        {n_rd, n_wr, n_brd, n_bwr, n_look, n_l2w, n_prio, n_stall} = '0;
    endtask
    // one request, held for the taking edge; optionally wait for done
    task automatic req(input logic w, input logic [2:0] a,
        input logic [63:0] va, input logic [39:0] pa, input logic [31:0] d,
        input logic [1:0] op, input logic wait_done);
        for (int k = 0; k < 400 && stall !== 1'b0; k++) begin
            @(posedge clk);
            #2;
        end
        {valid, wr, attr, vaddr, paddr, wdata, hinv, hwb} = {1'b1, w, a, va,
            pa, d, op};
        @(posedge clk);
        #2;
        {valid, hinv, hwb} = 3'h0;
        for (int k = 0; k < 400 && wait_done && done !== 1'b1; k++) begin
            @(posedge clk);
            #2;
        end
        got = rdata;
        if (wait_done) `CHK("done", 1'b1, done)
    endtask
    task automatic t_uncached();
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        lat = 4'h1;
        foreach (codes[i]) begin
            clr();
            req(1'b0, codes[i], 64'h0, 40'h0_1000_0040 + 40'(i * 8), 0, 0, 1);
            `CHK("uc rdata", 32'h4a5a_0040 ^ 32'(i * 8), got)
            quiet();
            `CHK("uc reads", 1, n_rd)
            `CHK("uc looks", 0, n_look)
        end
        clr();
        req(1'b0, 3'h3, 64'hffff_ffff_a000_0100, 40'h0_1000_0100, 0, 0, 1);
        quiet();
        `CHK("segment read", 1, n_rd)
        clr();
        req(1'b1, 3'h2, 64'h0, 40'h0_2000_0000, 32'hcafe_0001, 0, 1);
        quiet();
        `CHK("uc write", 1, n_wr)
        `CHK("uc wdata", 32'hcafe_0001, last_wd)
        `CHK("uc prio", 1'b1, n_prio > 0)
    endtask
    task automatic t_writeback();
        lat = 4'h9;
        l2_mode = 1'b0;
        clr();
        req(1'b0, 3'h3, 64'h0, 40'h0_3000_0020, 0, 0, 1);
        quiet();
        `CHK("miss look", 1, n_look)
        `CHK("miss block read", 1, n_brd)
        `CHK("miss l2 fill", 1'b1, n_l2w > 0)
        `CHK("miss no stall", 0, n_stall)
        clr();
        req(1'b1, 3'h3, 64'h0, 40'h0_3000_0024, 32'h1234_5678, 0, 1);
        quiet();
        `CHK("hit traffic", 0, n_look + n_brd + n_bwr + n_wr + n_l2w)
        l2_mode = 1'b1;
        clr();
        req(1'b1, 3'h3, 64'h0, 40'h0_3000_0140, 32'h9, 0, 1);
        quiet();
        `CHK("store miss look", 1, n_look)
        `CHK("l2 hit no read", 0, n_brd + n_wr)
        clr();
        req(1'b0, 3'h3, 64'h0, 40'h0_3000_0020, 0, 2'b01, 1);
        quiet();
        `CHK("dirty writeback", 1, n_bwr)
        clr();
        req(1'b0, 3'h3, 64'h0, 40'h0_3000_0020, 0, 0, 1);
        quiet();
        `CHK("refill after inval", 1, n_look)
        clr();
        req(1'b0, 3'h3, 64'h0, 40'h0_3000_0020, 0, 2'b10, 1);
        quiet();
        `CHK("clean inval", 1'b1, n_bwr == 0 && n_stall <= 2)
        clr();
        req(1'b0, 3'h3, 64'h0, 40'h0_3000_01e0, 0, 2'b10, 1);
        quiet();
        `CHK("miss inval stall", 0, n_stall)
    endtask
    task automatic t_accel();
        lat = 4'h2;
        clr();
        for (int i = 0; i < 8; i++) begin
            req(1'b1, 3'h7, 64'h0, 40'h0_4000_0000 + 40'(i * 4), 32'(i), 0, 1);
        end
        quiet();
        `CHK("gather block", 1, n_bwr)
        `CHK("gather singles", 0, n_wr)
        clr();
        for (int i = 0; i < 3; i++) begin
            req(1'b1, 3'h7, 64'h0, 40'h0_4000_0020 + 40'(i * 4), 32'(i), 0, 1);
        end
        req(1'b1, 3'h2, 64'h0, 40'h0_2000_0100, 32'h77, 0, 0);
        quiet();
        req(1'b1, 3'h2, 64'h0, 40'h0_2000_0100, 32'h77, 0, 1);
        quiet();
        `CHK("drain block", 0, n_bwr)
        `CHK("drain singles", 1'b1, n_wr >= 4)
    endtask
    task automatic t_sync();
        lat = 4'hc;
        clr();
        req(1'b1, 3'h2, 64'h0, 40'h0_2000_0200, 32'h55, 0, 0);
        {pend, sync} = 2'b11;
        repeat (5) @(posedge clk);
        #2;
        `CHK("sync stall", 1'b1, stall)
        pend = 1'b0;
        for (int k = 0; k < 60 && stall !== 1'b0; k++) begin
            @(posedge clk);
            #2;
        end
        sync = 1'b0;
        `CHK("sync release", 1'b0, stall)
        `CHK("sync store out", 1, n_wr)
    endtask
    initial begin
        {clk, rst_n, valid, wr, sync, hinv, hwb, pend, l2_mode} = '0;
        {vaddr, paddr, attr, wdata, lat} = '0;
        repeat (20) @(posedge clk);
        #2;
        rst_n = 1'b1;
        quiet();
        t_uncached();
        t_writeback();
        t_accel();
        quiet();
        t_sync();
        close_out();
    end
    initial begin
        #750000;
        err_total++;
        close_out();
    end
endmodule
bind memory_coherency_policy coherency_policy_sva chk (.CORE_CLK_I,
    .ARST_N_I, .REQ_SYNC_I, .LOADS_PENDING_I, .STALL_O, .DONE_O, .RDATA_O,
    .L2_DONE_I, .L2_HIT_I, .BUS_REQ_O, .BUS_PRIORITY_O, .BUS_KIND_O,
    .BUS_WRITE_O, .BUS_DONE_I, .BUS_RDATA_I);
